// *** src/bdm_addr.v ***
// Purpose: Address forming and access for the banked data memory
// Assumes: Core decode stage drives one request per cycle on the same clock
// Notes:   Full-address move takes two cycles; busy holds off new requests
`timescale 1ns/1ps
`default_nettype none
`include "bdm_map.vh"

module bdm_addr (
  input  wire                     clock,
  input  wire                     rst_n,
  input  wire                     clk_en,
  input  wire                     rd_req,
  input  wire                     wr_req,
  input  wire                     access_sel,
  input  wire [`BDM_OFS_W-1:0]    offset,
  input  wire [`BDM_DATA_W-1:0]   wr_data,
  input  wire                     load_bank_literal,
  input  wire [`BDM_DATA_W-1:0]   literal,
  input  wire                     move_full_address,
  input  wire [`BDM_ADDR_W-1:0]   move_src,
  input  wire [`BDM_ADDR_W-1:0]   move_dst,
  input  wire                     extended_set_enable,
  input  wire [`BDM_ADDR_W-1:0]   index_base,
  output wire                     busy,
  output reg  [`BDM_DATA_W-1:0]   rd_data_r,
  output reg                      access_done_r,
  output reg  [`BDM_BANK_W-1:0]   bank_pointer_r,
  output reg  [`BDM_ADDR_W-1:0]   last_addr_r
);

  // Move sequencer states
  localparam [0:0] ST_IDLE    = `BDM_ST_IDLE;
  localparam [0:0] ST_MOVE_WR = `BDM_ST_MOVE_WR;

  reg                     state_r;
  reg                     state_nxt;
  reg [`BDM_ADDR_W-1:0]   move_dst_r;
  reg [`BDM_DATA_W-1:0]   move_data_r;
  reg [`BDM_ADDR_W-1:0]   access_addr;
  reg [`BDM_ADDR_W-1:0]   banked_addr;
  reg [`BDM_ADDR_W-1:0]   cur_addr;
  reg [`BDM_DATA_W-1:0]   read_val;
  reg [`BDM_DATA_W-1:0]   write_val;
  wire [`BDM_DATA_W-1:0]  ram_rdata;
  wire [`BDM_BANK_W-1:0]  cur_bank;
  wire                    bank_impl;
  wire [`BDM_NUM_BANKS-1:0] impl_mask;
  wire                    is_bank_ptr;
  wire                    move_start;
  wire                    plain_rd;
  wire                    plain_wr;
  wire                    write_do;
  wire                    ram_we;

  assign busy = (state_r == ST_MOVE_WR);

  // Requests are taken only when no move is finishing
  assign move_start = move_full_address & ~busy;
  assign plain_rd   = rd_req & ~busy & ~move_full_address;
  assign plain_wr   = wr_req & ~busy & ~move_full_address;

  // Access bank map, standard or extended
  always @* begin
    if (extended_set_enable && (offset <= `BDM_XIDX_LIMIT)) begin
      // Low offsets become index-relative in the extended set
      access_addr = index_base + {{(`BDM_ADDR_W-`BDM_OFS_W){1'b0}}, offset};
    end else if (offset[`BDM_ACC_SPLIT_BIT]) begin
      access_addr = {`BDM_ACC_HIGH_BANK, offset};
    end else begin
      access_addr = {`BDM_ACC_LOW_BANK, offset};
    end
  end

  // Pick bank pointer or access map per instruction
  always @* begin
    if (access_sel) begin
      banked_addr = {bank_pointer_r, offset};
    end else begin
      banked_addr = access_addr;
    end
  end

  // Effective address of this cycle
  always @* begin
    if (busy) begin
      cur_addr = move_dst_r;
    end else if (move_full_address) begin
      cur_addr = move_src;
    end else begin
      cur_addr = banked_addr;
    end
  end

  assign cur_bank    = cur_addr[`BDM_BANK_MSB:`BDM_BANK_LSB];
  // One mask bit per bank, picked by the bank field
  assign impl_mask   = `BDM_IMPL_BANKS;
  assign bank_impl   = impl_mask[cur_bank];
  assign is_bank_ptr = (cur_addr == `BDM_BANK_PTR_ADDR);

  // Read value, with zero fill for absent locations
  always @* begin
    if (is_bank_ptr) begin
      read_val = {`BDM_PTR_PAD, bank_pointer_r};
    end else if (bank_impl) begin
      read_val = ram_rdata;
    end else begin
      read_val = `BDM_ZERO_BYTE;
    end
  end

  // Write source: moved byte or core data
  always @* begin
    if (busy) begin
      write_val = move_data_r;
    end else begin
      write_val = wr_data;
    end
  end

  assign write_do = plain_wr | busy;
  assign ram_we   = write_do & bank_impl & ~is_bank_ptr;

  bdm_ram u_ram (
    .clock   (clock),
    .clk_en  (clk_en),
    .wr_en   (ram_we),
    .addr    (cur_addr),
    .wr_data (write_val),
    .rd_data (ram_rdata)
  );

  // Move sequencer: read source, then write destination
  always @* begin
    case (state_r)
      ST_IDLE: begin
        if (move_start) begin
          state_nxt = ST_MOVE_WR;
        end else begin
          state_nxt = ST_IDLE;
        end
      end
      ST_MOVE_WR: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Sequencer and move latches
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r     <= ST_IDLE;
      move_dst_r  <= {`BDM_ADDR_W{1'b0}};
      move_data_r <= `BDM_ZERO_BYTE;
    end else if (clk_en) begin
      state_r <= state_nxt;
      if (move_start) begin
        // Source byte held so the destination may equal it
        move_dst_r  <= move_dst;
        move_data_r <= read_val;
      end
    end
  end

  // Bank pointer: literal load wins over a data write
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bank_pointer_r <= `BDM_BANK_PTR_RST;
    end else if (clk_en) begin
      if (load_bank_literal) begin
        bank_pointer_r <= literal[`BDM_BANK_W-1:0];
      end else if (write_do && is_bank_ptr) begin
        bank_pointer_r <= write_val[`BDM_BANK_W-1:0];
      end
    end
  end

  // Read data, done pulse and resolved address
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_r     <= `BDM_ZERO_BYTE;
      access_done_r <= 1'b0;
      last_addr_r   <= {`BDM_ADDR_W{1'b0}};
    end else if (clk_en) begin
      access_done_r <= plain_rd | plain_wr | busy;
      if (plain_rd || move_start) begin
        rd_data_r <= read_val;
      end
      if (plain_rd || plain_wr || move_start || busy) begin
        last_addr_r <= cur_addr;
      end
    end
  end

endmodule
`default_nettype wire

// *** src/bdm_map.vh ***
// Purpose: Constants for banked data memory addressing
// Assumes: One 50 MHz clock, 8-bit data, 12-bit byte addresses
// Notes:   Definitions only; included by bare name
// Summary of operation
// - Data memory uses 12-bit byte addresses, 4096 locations in all.
// - Space is 16 contiguous banks of 256 bytes; all 16 exist.
// - Reading any unimplemented location gives all zero bits.
// - Banked address is bank pointer as top 4 bits, opcode offset below.
// - Bank pointer keeps only low four bits; upper four read zero, ignore writes.
// - Load-bank-literal instruction loads the bank pointer directly.
// - Unimplemented bank: writes dropped, reads zero, completion still reported.
// - Full-address move uses its own 12-bit addresses, ignoring bank pointer.
// - Access map: 00h-7Fh to bank 0 start, 80h-FFh to bank 15 top.
// - Access bit 1 uses bank pointer plus offset; 0 uses access map.
// - Access-map operand access completes in one cycle, no pointer update needed.
// - Extended set enable of 1 makes offsets 00h-5Fh index-relative; offsets 60h-FFh keep the standard access map.
// - Special registers fill F80h through FFFh, reached by upper access offsets.
`ifndef BDM_MAP_VH
`define BDM_MAP_VH

`define BDM_ADDR_W        12
`define BDM_DATA_W        8
`define BDM_BANK_W        4
`define BDM_OFS_W         8
`define BDM_MEM_DEPTH     4096
`define BDM_NUM_BANKS     16
`define BDM_BANK_MSB      11
`define BDM_BANK_LSB      8
`define BDM_ACC_SPLIT_BIT 7
`define BDM_ACC_LOW_BANK  4'h0
`define BDM_ACC_HIGH_BANK 4'hF
`define BDM_SFR_BASE      12'hF80
`define BDM_BANK_PTR_ADDR 12'hFE0
`define BDM_BANK_PTR_RST  4'h0
`define BDM_PTR_PAD       4'h0
`define BDM_IMPL_BANKS    16'hFFFF
`define BDM_XIDX_LIMIT    8'h5F
`define BDM_ZERO_BYTE     8'h00
`define BDM_ST_IDLE       1'b0
`define BDM_ST_MOVE_WR    1'b1

`endif

// *** src/bdm_ram.v ***
// Purpose: Byte-wide static store for the whole data space
// Assumes: Write on clock edge, read combinational
// Notes:   Contents are not cleared by reset, like real data RAM
`timescale 1ns/1ps
`default_nettype none
`include "bdm_map.vh"

module bdm_ram (
  input  wire                     clock,
  input  wire                     clk_en,
  input  wire                     wr_en,
  input  wire [`BDM_ADDR_W-1:0]   addr,
  input  wire [`BDM_DATA_W-1:0]   wr_data,
  output wire [`BDM_DATA_W-1:0]   rd_data
);

  reg [`BDM_DATA_W-1:0] mem [0:`BDM_MEM_DEPTH-1];

  // Store one byte when enabled
  always @(posedge clock) begin
    if (clk_en && wr_en) begin
      mem[addr] <= wr_data;
    end
  end

  // Old data is seen on a same-cycle read and write
  assign rd_data = mem[addr];

endmodule
`default_nettype wire

// *** tb/bdm_addr_asserts.sv ***
// Purpose: Port checks for bank address forming
// Assumes: One clock; clk_en low freezes all state
// Notes:   Bound onto the top module below
`timescale 1ns/1ps
`default_nettype none
module bdm_addr_asserts (
  input wire logic        clock, rst_n, clk_en, rd_req, wr_req, access_sel, busy,
  input wire logic        load_bank_literal, move_full_address, access_done_r,
  input wire logic        extended_set_enable,
  input wire logic [7:0]  offset, literal, rd_data_r,
  input wire logic [11:0] move_src, move_dst, last_addr_r,
  input wire logic [3:0]  bank_pointer_r
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Requests taken at this edge
  wire acc  = clk_en && !busy && !move_full_address && (rd_req || wr_req);
  wire amap = acc && !access_sel;
  // Move: source cycle with busy, then destination cycle
  sequence s_src; busy && last_addr_r == $past(move_src); endsequence
  sequence s_dst; !busy && access_done_r && last_addr_r == $past(move_dst, 2); endsequence
  property p_move; clk_en && !busy && move_full_address |=> s_src ##1 s_dst; endproperty
  a_move: assert property (p_move) else $error("move steps");
  property p_done; acc |=> access_done_r && !busy; endproperty
  a_done: assert property (p_done) else $error("access late");
  property p_ptr;
    clk_en && load_bank_literal |=> {4'h0, bank_pointer_r} == ($past(literal) & 8'h0F);
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer load");
  property p_bank; acc && access_sel |=> last_addr_r == {$past(bank_pointer_r), $past(offset)};
  endproperty
  a_bank: assert property (p_bank) else $error("banked address");
  property p_low; amap && !extended_set_enable && !offset[7] |=> last_addr_r == $past(offset);
  endproperty
  a_low: assert property (p_low) else $error("access low");
  property p_high; amap && offset[7] |=> last_addr_r == {4'hF, $past(offset)}; endproperty
  a_high: assert property (p_high) else $error("access high");
  property p_pad;
    amap && rd_req && offset == 8'hE0 |=> rd_data_r == {4'h0, $past(bank_pointer_r)};
  endproperty
  a_pad: assert property (p_pad) else $error("pointer pad");
endmodule
bind bdm_addr bdm_addr_asserts chk (.*);
`default_nettype wire

// *** tb/bdm_core.sv ***
// Purpose: Core decode stage issuing operand requests
// Assumes: Caller enters just after a rising edge
// Notes:   Requests hold through the taking edge
`timescale 1ns/1ps
`default_nettype none
module bdm_core (
  input  wire logic   clock,
  output logic        rd_req, wr_req, access_sel, load_bank_literal,
  output logic        move_full_address, extended_set_enable,
  output logic [7:0]  offset, wr_data, literal,
  output logic [11:0] move_src, move_dst, index_base
);
  // Quiet from time zero
  initial {rd_req, wr_req, access_sel, load_bank_literal, move_full_address,
    extended_set_enable, offset, wr_data, literal, move_src, move_dst, index_base} = '0;
  // One access cycle; left asserted so calls run back to back
  task op(input r, w, a, l, input [7:0] o, d);
    {rd_req, wr_req, access_sel, load_bank_literal, offset, wr_data, literal} =
      {r, w, a, l, o, d, d};
    @(posedge clock);
    #1;
  endtask
  // Extended map level and its index base
  task ext(input e, input [11:0] b);
    {extended_set_enable, index_base} = {e, b};
  endtask
  // Move: taken edge, busy cycle, then done
  task mv(input [11:0] src, dst);
    {rd_req, wr_req, load_bank_literal, move_full_address, move_src, move_dst} =
      {4'b0001, src, dst};
    @(posedge clock);
    #1 move_full_address = 0;
    @(posedge clock);
    #1;
  endtask
endmodule
`default_nettype wire

// *** tb/bdm_addr_tb.sv ***
// Purpose: Self-checking bench for bank address forming
// Assumes: Locations written before read
// Notes:   Model keeps its own memory and pointer
`timescale 1ns/1ps
`default_nettype none
module bdm_addr_tb;
  logic clock = 0, rst_n = 0, clk_en = 1;
  wire rd_req, wr_req, access_sel, load_bank_literal, move_full_address;
  wire extended_set_enable, busy, access_done_r;
  wire [7:0] offset, wr_data, literal, rd_data_r;
  wire [11:0] move_src, move_dst, index_base, last_addr_r;
  wire [3:0] bank_pointer_r;
  logic [7:0] m [0:4095];
  logic [3:0] mbp = 0;
  logic [31:0] s = 32'h26d7_f73c;
  int miscompares = 0, n_tests = 0, cyc = 0;
  bdm_addr uut (.*);
  bdm_core core (.*);
  always #10 clock = ~clock;
  function automatic [31:0] nx(input [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Reference address forming
  function automatic [11:0] res(input a, input [7:0] o);
    if (a) return {mbp, o};
    if (extended_set_enable && o <= 8'h5F) return index_base + o;
    return {o[7] ? 4'hF : 4'h0, o};
  endfunction
  task chk(input string n, input [11:0] e, g);
    n_tests++;
    if (e !== g) begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // Access, compare, then update model
  task automatic acc(input r, w, a, input [7:0] o, d);
    logic [11:0] ad;
    core.op(r, w, a, 1'b0, o, d);
    ad = res(a, o);
    chk("addr", ad, last_addr_r);
    chk("done", 1, access_done_r);
    if (r) chk("data", ad == 12'hFE0 ? {4'h0, mbp} : m[ad], rd_data_r);
    if (w && ad == 12'hFE0) mbp = d[3:0];
    else if (w) m[ad] = d;
  endtask
  task automatic ld(input [3:0] b);
    s = nx(s);
    core.op(0, 0, 0, 1, 0, {s[7:4], b});
    mbp = b;
    chk("ptr", b, bank_pointer_r);
  endtask
  task give_verdict;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      miscompares++;
      give_verdict;
    end
  end
  initial begin
    repeat (16) @(posedge clock);
    #1 rst_n = 1;
    chk("rst", 0, {busy, bank_pointer_r});
    chk("rst_addr", 0, last_addr_r);
    chk("rst_data", 0, {access_done_r, rd_data_r});
    for (int i = 0; i < 16; i++) ld(i);
    $display("T1 end");
    for (int i = 0; i < 16; i++) begin
      ld(i);
      s = nx(s);
      acc(0, 1, 1, s[7:0], s[15:8]);
      acc(1, 1, 1, s[7:0], s[23:16]);
    end
    $display("T2 end");
    acc(0, 1, 0, 8'hE0, 8'hFF);
    acc(1, 0, 0, 8'hE0, 0);
    for (int i = 0; i < 24; i++) begin
      s = nx(s);
      acc(0, 1, 0, s[7:0], s[15:8]);
      acc(1, 0, 0, s[7:0], 0);
    end
    $display("T3 end");
    core.ext(1'b1, s[11:0]);
    for (int i = 0; i < 8; i++) begin
      s = nx(s);
      acc(0, 1, 0, s[7:0] & 8'h7F, s[15:8]);
      acc(1, 0, 0, s[7:0] & 8'h7F, 0);
    end
    core.ext(1'b0, 12'h000);
    $display("T4 end");
    acc(0, 1, 0, 8'h10, s[7:0]);
    ld(4'hC);
    core.mv(12'h010, 12'hA34);
    chk("mvdata", m[12'h010], rd_data_r);
    m[12'hA34] = m[12'h010];
    ld(4'hA);
    acc(1, 0, 1, 8'h34, 0);
    core.op(0, 0, 0, 0, 0, 0);
    $display("T5 end");
    // Frozen cycles leave memory, pointer and address alone
    acc(0, 1, 0, 8'h20, 8'hA5);
    clk_en = 0;
    core.op(0, 1, 0, 0, 8'h20, 8'h5A);
    core.op(0, 0, 0, 1, 8'h00, 8'h03);
    clk_en = 1;
    chk("frz_ptr", mbp, bank_pointer_r);
    chk("frz_addr", 12'h020, last_addr_r);
    acc(1, 0, 0, 8'h20, 0);
    $display("T6 end");
    // Reset in mid-run clears pointer and outputs
    rst_n = 0;
    @(posedge clock);
    #1 rst_n = 1;
    mbp = 0;
    chk("rst_ptr", 0, {busy, access_done_r, bank_pointer_r});
    chk("rst_addr", 0, last_addr_r);
    acc(1, 0, 0, 8'hE0, 0);
    $display("T7 end");
    give_verdict;
  end
endmodule
`default_nettype wire
